// file: llwd_pkg.sv
// Shared constants, types and field layout of the LIN LED write-command decoder.
package llwd_pkg;

  // Frame identifiers.
  localparam logic [7:0] PID_LED_CTRL = 8'hA3;
  localparam logic [7:0] PID_COLOR    = 8'h64;
  localparam logic [7:0] PID_SHORT    = 8'h6F;
  localparam logic [7:0] PID_INTENS   = 8'h2E;
  localparam logic [7:0] PID_PRIM_CAL = 8'h25;

  // Data byte counts per frame, checksum not included.
  localparam logic [3:0] LEN_LED_CTRL = 4'h4;
  localparam logic [3:0] LEN_COLOR    = 4'h8;
  localparam logic [3:0] LEN_SHORT    = 4'h4;
  localparam logic [3:0] LEN_INTENS   = 4'h2;
  localparam logic [3:0] LEN_PRIM_CAL = 4'h4;
  localparam logic [3:0] MAX_DATA     = 4'h8;
  localparam int         BUF_DEPTH    = 8;

  // Field positions and markers.
  localparam int         ADDR_MODE_BIT = 7;
  localparam logic [1:0] APPLY_NOW     = 2'h0;
  localparam logic [1:0] APPLY_STORE   = 2'h1;
  localparam logic [1:0] APPLY_STORED  = 2'h2;
  localparam logic [1:0] APPLY_DISCARD = 2'h3;
  localparam logic [3:0] SHORT_MARK    = 4'hF;
  localparam logic [1:0] INTENS_MARK   = 2'h3;
  localparam logic [7:0] CKSUM_GOOD    = 8'hFF;

  // Coefficient scaling: 0x80 is unity, results saturate.
  localparam int         SCALE_MSB = 15;
  localparam int         SCALE_LSB = 7;
  localparam logic [7:0] SCALE_SAT = 8'hFF;

  // Register map, byte addresses.
  localparam int         AXI_AW     = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATE  = 8'h04;
  localparam logic [7:0] REG_MOD    = 8'h08;
  localparam logic [7:0] REG_STORED = 8'h0C;
  localparam logic [7:0] REG_COEF   = 8'h10;
  localparam logic [7:0] REG_COUNT  = 8'h14;
  localparam logic [7:0] REG_IDENT  = 8'h18;
  localparam logic       CTRL_RESET = 1'h1;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum {CMD_NONE, CMD_LED_CTRL, CMD_COLOR, CMD_SHORT, CMD_INTENS, CMD_PRIM_CAL} llwd_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } llwd_lin_byte_t;

  typedef struct packed {
    logic [5:0] node;
    logic [3:0] group_membership_bits;
    logic [7:0] diag_coef_third;
    logic [7:0] diag_coef_second;
    logic [7:0] diag_coef_first;
  } llwd_otp_t;

  typedef struct packed {
    logic       cal_en;
    logic       modulation_freq_select;
    logic       leds_on;
    logic       thermal_control;
    logic [2:0] led_en;
    logic       fade_on;
    logic       fade_slope;
    logic [5:0] fade_time;
    logic [3:0] intensity;
  } llwd_led_state_t;

endpackage : llwd_pkg

// file: llwd_cksum.sv
// Classic LIN checksum accumulator with end-around carry.
`timescale 1ns/10ps
module llwd_cksum (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] data,
  output logic      [7:0] sum
);
  import llwd_pkg::*;

  logic [7:0] sum_r;
  wire  [8:0] raw_sum = {1'b0, sum_r} + {1'b0, data};
  wire  [7:0] sum_nxt = raw_sum[7:0] + {7'h00, raw_sum[8]};

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      sum_r <= 8'h00;
    end else if (add) begin
      sum_r <= sum_nxt;
    end
  end

  assign sum = sum_r;

endmodule : llwd_cksum

// file: llwd_diag_scale.sv
// One channel of the diagonal calibration: registered value times coefficient.
`timescale 1ns/10ps
module llwd_diag_scale (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       in_vld,
  input  wire logic [7:0] value,
  input  wire logic [7:0] coef,
  output logic            out_vld,
  output logic      [7:0] result
);
  import llwd_pkg::*;

  wire [15:0] prod   = {8'h00, value} * {8'h00, coef};
  wire  [7:0] scaled = prod[SCALE_MSB] ? SCALE_SAT : prod[SCALE_MSB-1:SCALE_LSB];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_vld <= 1'b0;
      result  <= 8'h00;
    end else begin
      out_vld <= in_vld;
      result  <= scaled;
    end
  end

endmodule : llwd_diag_scale

// file: llwd_cmd_decoder.sv
// LIN write-command decoder for an RGB LED node, with AXI4-Lite status and control.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module llwd_cmd_decoder (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire llwd_pkg::llwd_lin_byte_t  lin_byte,
  input  wire llwd_pkg::llwd_otp_t       otp,
  input  wire logic                      s_axi_awvalid,
  input  wire logic [7:0]                s_axi_awaddr,
  output logic                           s_axi_awready,
  input  wire logic                      s_axi_wvalid,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output logic                           s_axi_wready,
  output logic                           s_axi_bvalid,
  output logic [1:0]                     s_axi_bresp,
  input  wire logic                      s_axi_bready,
  input  wire logic                      s_axi_arvalid,
  input  wire logic [7:0]                s_axi_araddr,
  output logic                           s_axi_arready,
  output logic                           s_axi_rvalid,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  input  wire logic                      s_axi_rready,
  output llwd_pkg::llwd_led_state_t      led_state,
  output logic [2:0][7:0]                mod_value,
  output logic [2:0][7:0]                diag_coef
);
  import llwd_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic llwd_cmd_t decode_pid(input logic [7:0] pid);
    case (pid)
      PID_LED_CTRL: decode_pid = CMD_LED_CTRL;
      PID_COLOR:    decode_pid = CMD_COLOR;
      PID_SHORT:    decode_pid = CMD_SHORT;
      PID_INTENS:   decode_pid = CMD_INTENS;
      PID_PRIM_CAL: decode_pid = CMD_PRIM_CAL;
      default:      decode_pid = CMD_NONE;
    endcase
  endfunction : decode_pid

  function automatic logic [3:0] cmd_len(input llwd_cmd_t c);
    case (c)
      CMD_LED_CTRL: cmd_len = LEN_LED_CTRL;
      CMD_COLOR:    cmd_len = LEN_COLOR;
      CMD_SHORT:    cmd_len = LEN_SHORT;
      CMD_INTENS:   cmd_len = LEN_INTENS;
      CMD_PRIM_CAL: cmd_len = LEN_PRIM_CAL;
      default:      cmd_len = 4'h0;
    endcase
  endfunction : cmd_len

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == REG_CTRL) || (a == REG_STATE) || (a == REG_MOD) ||
                (a == REG_STORED) || (a == REG_COEF) || (a == REG_COUNT) ||
                (a == REG_IDENT);
  endfunction : is_mapped

  //////////////////////////////////////////////////////////////////////////////////////////
  // Frame intake.

  logic [7:0]      buf_r [0:BUF_DEPTH-1];
  logic [3:0]      idx_r;
  llwd_cmd_t       cmd_r;
  logic            in_frame_r;
  logic            commit_r;
  logic            dec_en_r;
  logic [7:0]      sum;

  wire take_pid  = lin_byte.valid & lin_byte.first;
  wire take_data = lin_byte.valid & ~lin_byte.first & ~lin_byte.last & in_frame_r;
  wire take_end  = lin_byte.valid & ~lin_byte.first & lin_byte.last & in_frame_r;
  wire sum_ok    = (sum + lin_byte.data) == CKSUM_GOOD;
  wire len_ok    = idx_r == cmd_len(cmd_r);
  wire known     = cmd_r != CMD_NONE;
  wire frame_ok  = take_end & known & dec_en_r & sum_ok & len_ok;
  wire frame_bad = take_end & known & dec_en_r & ~(sum_ok & len_ok);

  llwd_cksum u_cksum (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (take_pid),
    .add     (take_data),
    .data    (lin_byte.data),
    .sum     (sum)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame_r <= 1'b0;
      idx_r      <= 4'h0;
      cmd_r      <= CMD_NONE;
      commit_r   <= 1'b0;
    end else begin
      commit_r <= frame_ok;
      if (take_pid) begin
        in_frame_r <= 1'b1;
        idx_r      <= 4'h0;
        cmd_r      <= decode_pid(lin_byte.data);
      end else if (take_data) begin
        idx_r <= (idx_r > MAX_DATA) ? idx_r : idx_r + 4'h1;
      end else if (take_end) begin
        in_frame_r <= 1'b0;
      end
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < BUF_DEPTH; gb++) begin : g_buf
      always_ff @(posedge aclk) begin
        if (take_data && idx_r == 4'(gb)) begin
          buf_r[gb] <= lin_byte.data;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////////////////
  // Addressing and command decode.

  logic [5:0]      node_r;
  logic [3:0]      group_r;
  logic            otp_load_r;

  wire [7:0]       d1 = buf_r[0];
  wire [7:0]       d2 = buf_r[1];
  wire [7:0]       d3 = buf_r[2];
  wire [7:0]       d4 = buf_r[3];
  wire [7:0]       d5 = buf_r[4];
  wire [15:0]      grp_mask  = {d3, d2};
  wire [2:0][7:0]  color_rx  = {buf_r[7], buf_r[6], buf_r[5]};
  wire [2:0][7:0]  short_rx  = {d3, d2, d1};
  wire [1:0]       apply_code = d4[7:6];

  wire node_match = d1[5:0] == node_r;
  wire node_hit   = d1[ADDR_MODE_BIT] ? node_match : grp_mask[group_r];
  wire cgrp_hit   = (d4[7:4] == SHORT_MARK) & d4[group_r[1:0]];
  wire igrp_hit   = (d2[7:6] == INTENS_MARK) & d1[4 + group_r[3:2]];

  wire ex_led    = commit_r & (cmd_r == CMD_LED_CTRL) & node_hit;
  wire ex_color  = commit_r & (cmd_r == CMD_COLOR) & node_hit & (apply_code != APPLY_DISCARD);
  wire ex_short  = commit_r & (cmd_r == CMD_SHORT) & cgrp_hit;
  wire ex_intens = commit_r & (cmd_r == CMD_INTENS) & igrp_hit;
  wire ex_cal    = commit_r & (cmd_r == CMD_PRIM_CAL) & node_hit;

  wire col_store  = ex_color & ((apply_code == APPLY_NOW) | (apply_code == APPLY_STORE));
  wire col_new    = (ex_color & (apply_code == APPLY_NOW)) | ex_short;
  wire col_old    = ex_color & (apply_code == APPLY_STORED);
  wire col_params = ex_color & (apply_code != APPLY_STORE);

  //////////////////////////////////////////////////////////////////////////////////////////
  // LED state, colour staging and calibration.

  llwd_led_state_t led_r;
  logic [2:0][7:0] stored_r;
  logic [2:0][7:0] src_r;
  logic [2:0][7:0] mod_r;
  logic [2:0][7:0] coef_r;
  logic [2:0][7:0] scaled;
  logic [2:0]      scl_vld;
  logic            apply_r;

  wire [2:0][7:0]  src_nxt = col_old ? stored_r : (ex_short ? short_rx : color_rx);
  wire [6:0]       led_ctrl_now = {led_r.cal_en, led_r.modulation_freq_select, led_r.leds_on,
                                   led_r.thermal_control, led_r.led_en};
  wire [2:0][7:0]  otp_coefs = {otp.diag_coef_third, otp.diag_coef_second,
                                otp.diag_coef_first};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_r      <= '0;
      stored_r   <= '0;
      src_r      <= '0;
      mod_r      <= '0;
      apply_r    <= 1'b0;
      otp_load_r <= 1'b1;
      node_r     <= 6'h00;
      group_r    <= 4'h0;
      coef_r     <= '0;
    end else begin
      otp_load_r <= 1'b0;
      apply_r    <= col_new | col_old;
      if (otp_load_r) begin
        node_r  <= otp.node;
        group_r <= otp.group_membership_bits;
        coef_r  <= otp_coefs;
      end else if (ex_cal) begin
        coef_r  <= {d4, d3, d2};
      end
      if (ex_led) begin
        {led_r.cal_en, led_r.modulation_freq_select, led_r.leds_on,
         led_r.thermal_control, led_r.led_en} <= d4[7:1];
      end
      if (col_params) begin
        led_r.fade_time  <= d4[5:0];
        led_r.fade_on    <= d5[7];
        led_r.fade_slope <= d5[6];
        led_r.leds_on    <= d5[5];
        led_r.intensity  <= d5[3:0];
      end
      if (ex_intens) begin
        led_r.intensity <= d1[3:0];
        led_r.fade_time <= d2[5:0];
      end
      if (col_store) begin
        stored_r <= color_rx;
      end
      if (col_new | col_old) begin
        src_r <= src_nxt;
      end
      if (scl_vld[0]) begin
        mod_r <= led_r.cal_en ? scaled : src_r;
      end
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_scale
      llwd_diag_scale u_scale (
        .aclk    (aclk),
        .aresetn (aresetn),
        .in_vld  (apply_r),
        .value   (src_r[gc]),
        .coef    (coef_r[gc]),
        .out_vld (scl_vld[gc]),
        .result  (scaled[gc])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic [15:0] ok_cnt_r;
  logic [15:0] bad_cnt_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire do_wr    = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire aw_nxt   = ~do_wr & (aw_hold_r | aw_hs);
  wire w_nxt    = ~do_wr & (w_hold_r | w_hs);
  wire ar_hs    = s_axi_arvalid & s_axi_arready;
  wire rv_nxt   = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire wr_ctrl  = do_wr & (waddr_r == REG_CTRL) & wstrb_r[0];
  wire cnt_clr  = do_wr & (waddr_r == REG_COUNT);

  wire [31:0] state_word = {12'h000, led_r.fade_slope, led_r.fade_on, led_r.fade_time,
                            led_r.intensity, 1'b0, led_r.led_en, led_r.thermal_control,
                            led_r.leds_on, led_r.modulation_freq_select, led_r.cal_en};
  wire [31:0] rd_word =
      (s_axi_araddr == REG_CTRL)   ? {31'h00000000, dec_en_r} :
      (s_axi_araddr == REG_STATE)  ? state_word :
      (s_axi_araddr == REG_MOD)    ? {8'h00, mod_r} :
      (s_axi_araddr == REG_STORED) ? {8'h00, stored_r} :
      (s_axi_araddr == REG_COEF)   ? {8'h00, coef_r} :
      (s_axi_araddr == REG_COUNT)  ? {bad_cnt_r, ok_cnt_r} :
      (s_axi_araddr == REG_IDENT)  ? {20'h00000, group_r, 2'h0, node_r} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      waddr_r       <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      dec_en_r      <= CTRL_RESET;
      ok_cnt_r      <= 16'h0000;
      bad_cnt_r     <= 16'h0000;
    end else begin
      aw_hold_r     <= aw_nxt;
      w_hold_r      <= w_nxt;
      s_axi_awready <= ~aw_nxt;
      s_axi_wready  <= ~w_nxt;
      s_axi_arready <= ~rv_nxt;
      s_axi_rvalid  <= rv_nxt;
      if (aw_hs) begin
        waddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(waddr_r) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end
      if (wr_ctrl) begin
        dec_en_r <= wdata_r[0];
      end
      // A frame counted in the clearing cycle is kept.
      ok_cnt_r  <= (cnt_clr ? 16'h0000 : ok_cnt_r) + {15'h0000, frame_ok};
      bad_cnt_r <= (cnt_clr ? 16'h0000 : bad_cnt_r) + {15'h0000, frame_bad};
    end
  end

  assign led_state = led_r;
  assign mod_value = mod_r;
  assign diag_coef = coef_r;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_apply_path;
    apply_r ##1 scl_vld[0];
  endsequence

  a_led_ctrl_upd: assert property (ex_led |=> led_ctrl_now == $past(d4[7:1]))
    else $error("LED control bits not applied");
  a_group_gate: assert property (commit_r && cmd_r == CMD_LED_CTRL && !d1[ADDR_MODE_BIT]
      && !grp_mask[group_r] |=> $stable(led_ctrl_now))
    else $error("Group miss changed LED control");
  a_node_gate: assert property (commit_r && cmd_r == CMD_LED_CTRL && d1[ADDR_MODE_BIT]
      && !node_match |=> $stable(led_ctrl_now))
    else $error("Node miss changed LED control");
  a_raw_load: assert property ((col_new && !led_r.cal_en && !ex_led) ##1 s_apply_path
      |=> mod_r == $past(src_r, 2))
    else $error("Uncalibrated colour not loaded raw");
  a_cal_load: assert property ((col_new && led_r.cal_en) ##1 s_apply_path
      |=> mod_r == $past(scaled))
    else $error("Calibrated colour not loaded");
  a_store_only: assert property (ex_color && apply_code == APPLY_STORE
      |=> !apply_r && stored_r == $past(color_rx) ##1 !scl_vld[0])
    else $error("Store-only frame touched modulation");
  a_short_hit: assert property (commit_r && cmd_r == CMD_SHORT && d4[7:4] == SHORT_MARK
      && d4[group_r[1:0]] |=> apply_r && src_r == $past(short_rx))
    else $error("Short colour for own group not applied");
  a_intens_upd: assert property (ex_intens
      |=> led_r.intensity == $past(d1[3:0]) && led_r.fade_time == $past(d2[5:0]))
    else $error("Intensity frame not applied");
  a_slope_kept: assert property (col_params |=> led_r.fade_slope == $past(d5[6]))
    else $error("Fade slope not taken");
  a_coef_otp: assert property (otp_load_r |=> coef_r == $past(otp_coefs))
    else $error("Coefficients not loaded from OTP");
  a_bad_sum: assert property (take_end && !sum_ok |=> !commit_r)
    else $error("Frame with bad checksum committed");
  a_pid_map: assert property (take_pid && lin_byte.data == PID_SHORT
      |=> cmd_r == CMD_SHORT)
    else $error("Short colour identifier not recognised");

endmodule : llwd_cmd_decoder

// file: llwd_lin_master.sv
// Far-side LIN master model that sends write frames one byte per pulse.
`timescale 1ns/10ps
module llwd_lin_master (
  input  wire logic                aclk,
  output llwd_pkg::llwd_lin_byte_t lin_byte
);
  import llwd_pkg::*;

  initial lin_byte = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Sends identifier, n data bytes with d1 lowest, then the checksum; bad spoils it.
  // The idle data byte is the inverse of the last one, so a stale value never matches.
  task automatic send(input logic [7:0] pid, input logic [63:0] d, input int n,
                      input logic bad);
    logic [8:0] t;
    logic [7:0] acc;
    acc = 8'h00;
    lin_byte <= '{1'b1, 1'b1, 1'b0, pid};
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      lin_byte <= '{1'b1, 1'b0, 1'b0, d[8*i +: 8]};
      t = acc + d[8*i +: 8];
      acc = t[7:0] + t[8];
    end
    @(posedge aclk);
    lin_byte <= '{1'b1, 1'b0, 1'b1, ~acc ^ {7'h00, bad}};
    @(posedge aclk);
    lin_byte <= '{1'b0, 1'b0, 1'b0, acc ^ {7'h00, bad}};
    @(posedge aclk);
  endtask : send
endmodule : llwd_lin_master

// file: tb.sv
// Self-checking bench for the LIN LED write-command decoder.
`timescale 1ns/10ps
module tb;
  import llwd_pkg::*;
  localparam logic [5:0] NODE = 6'h15;
  localparam logic [7:0] ND   = {2'b11, NODE};
  logic                  aclk, aresetn;
  llwd_lin_byte_t        lin_byte;
  llwd_otp_t             otp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata, rd;
  logic [1:0]            bresp, rresp, rs;
  llwd_led_state_t       led_state;
  logic [2:0][7:0]       mod_value, diag_coef;
  logic [6:0]            ctl;
  int                    num_checks, fail_count;

  assign ctl = {led_state.cal_en, led_state.modulation_freq_select, led_state.leds_on,
                led_state.thermal_control, led_state.led_en};

  llwd_lin_master lm (.aclk(aclk), .lin_byte(lin_byte));
  llwd_cmd_decoder dut (.aclk(aclk), .aresetn(aresetn), .lin_byte(lin_byte), .otp(otp),
    .s_axi_awvalid(awvalid), .s_axi_awaddr(awaddr), .s_axi_awready(awready),
    .s_axi_wvalid(wvalid), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wready(wready),
    .s_axi_bvalid(bvalid), .s_axi_bresp(bresp), .s_axi_bready(bready),
    .s_axi_arvalid(arvalid), .s_axi_araddr(araddr), .s_axi_arready(arready),
    .s_axi_rvalid(rvalid), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rready(rready),
    .led_state(led_state), .mod_value(mod_value), .diag_coef(diag_coef));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Sends one frame, then lets the commit and the calibration pipeline settle.
  task automatic frm(input logic [7:0] pid, input logic [63:0] d, input int n,
                     input logic bad = 1'b0);
    lm.send(pid, d, n, bad);
    repeat (5) @(posedge aclk);
  endtask : frm

  task automatic col(input logic [1:0] ap, input logic [7:0] c1, c2, c3);
    frm(PID_COLOR, {c3, c2, c1, 8'hF5, ap, 6'h0A, 16'h0000, ND}, 8);
  endtask : col

  task automatic note(input string s);
    $display("Test %s finished at %0t", s, $time);
  endtask : note

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    otp = '{NODE, 4'b1001, 8'hFF, 8'h80, 8'h40};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(diag_coef, 24'hFF8040);
    chk(led_state, 32'h0);
    axi_rd(REG_CTRL, rd, rs);
    chk(rd, 32'h1);
    axi_rd(REG_IDENT, rd, rs);
    chk(rd, 32'h915);
    axi_rd(8'h1C, rd, rs);
    chk(rd, 32'h0);
    chk(rs, RESP_DECERR);
    axi_wr(8'h1C, 32'h1, rs);
    chk(rs, RESP_DECERR);
    note("reset");
    frm(PID_LED_CTRL, {8'h5B, 16'h0000, ND}, 4);
    chk(ctl, 7'h2D);
    frm(PID_LED_CTRL, {8'hFF, 16'h0000, ND ^ 8'h01}, 4);
    chk(ctl, 7'h2D);
    frm(PID_LED_CTRL, {8'hFF, 16'hFDFF, 2'b01, NODE}, 4);
    chk(ctl, 7'h2D);
    axi_wr(REG_COUNT, 32'h0, rs);
    chk(rs, RESP_OKAY);
    frm(PID_LED_CTRL, {8'hFF, 16'h0000, ND}, 4, 1'b1);
    chk(ctl, 7'h2D);
    frm(PID_LED_CTRL, {8'h27, 16'h0200, 8'h00}, 4);
    chk(ctl, 7'h13);
    axi_rd(REG_COUNT, rd, rs);
    chk(rd, 32'h0001_0001);
    note("led control");
    for (int i = 0; i < 4; i++) begin
      col(2'(i), 8'h11 + 8'(8'h33 * i), 8'h22 + 8'(8'h33 * i), 8'h33 + 8'(8'h33 * i));
      chk(mod_value, (i < 2) ? 24'h332211 : 24'h665544);
    end
    chk({led_state.fade_on, led_state.fade_slope, led_state.fade_time, led_state.intensity},
        12'hCA5);
    frm(PID_LED_CTRL, {8'hA7, 16'h0000, ND}, 4);
    col(APPLY_NOW, 8'h80, 8'h80, 8'h80);
    chk(mod_value, 24'hFF8040);
    frm(PID_LED_CTRL, {8'h27, 16'h0000, ND}, 4);
    frm(PID_SHORT, {8'hF2, 8'h03, 8'h02, 8'h01}, 4);
    chk(mod_value, 24'h030201);
    frm(PID_SHORT, {8'hFD, 8'h09, 8'h08, 8'h07}, 4);
    chk(mod_value, 24'h030201);
    note("colour");
    frm(PID_INTENS, {8'hEB, 8'h4A}, 2);
    chk({led_state.fade_time, led_state.intensity}, 10'h2BA);
    frm(PID_INTENS, {8'hC1, 8'hB3}, 2);
    chk({led_state.fade_time, led_state.intensity}, 10'h2BA);
    frm(PID_PRIM_CAL, {8'h33, 8'h22, 8'h11, ND}, 4);
    chk(diag_coef, 24'h332211);
    frm(PID_PRIM_CAL, {8'h66, 8'h55, 8'h44, ND ^ 8'h01}, 4);
    chk(diag_coef, 24'h332211);
    note("intensity and calibration");
    axi_rd(REG_MOD, rd, rs);
    chk(rd, 32'h00030201);
    axi_rd(REG_STORED, rd, rs);
    chk(rd, 32'h00808080);
    axi_rd(REG_COEF, rd, rs);
    chk(rd, 32'h00332211);
    axi_wr(REG_CTRL, 32'h0, rs);
    chk(rs, RESP_OKAY);
    frm(PID_LED_CTRL, {8'hFF, 16'h0000, ND}, 4);
    chk(ctl, 7'h13);
    axi_wr(REG_CTRL, 32'h1, rs);
    frm(8'h3C, {8'hFF, 16'h0000, ND}, 4);
    chk(ctl, 7'h13);
    frm(PID_LED_CTRL, {8'hFF, 16'h0000, ND}, 4);
    chk(ctl, 7'h7F);
    axi_rd(REG_STATE, rd, rs);
    chk(rd, 32'h000EBA7F);
    note("registers");
    tally_and_finish();
  end
endmodule : tb
